// ===== hdl/ci_arb_device.sv
// Device end: frame timing, C/I registers, arbitration and AHB-Lite slave
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ci_arb_device (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic [3:0] layer1_indication,
  output logic [3:0] layer1_command,
  input wire logic hdlc_pending,
  input wire logic d_channel_stop,
  ci_link_if.dev link
);
  logic [3:0] primary_ci_receive_reg;
  logic [4:0] primary_ci_transmit_reg;
  logic [5:0] secondary_ci_receive_reg;
  logic [5:0] secondary_ci_transmit_reg;
  logic [2:0] interrupt_status_reg;
  logic [2:0] interrupt_mask_reg;
  logic [2:0] sync_timing_control_reg;
  logic serial_port_control_reg;
  logic [2:0] data_interface_mode_field;
  logic [2:0] cyc_reg;
  logic [4:0] bit_reg;
  logic [4:0] nbit;
  logic last_cyc;
  logic up_meta_reg;
  logic up_s;
  logic [4:0] up_sh_reg;
  logic [5:0] up_word;
  logic [3:0] ind_prev_reg;
  logic [3:0] cur_ind;
  logic [3:0] ext_code_reg;
  logic terminal;
  logic arb_on;
  logic req;
  logic arb_drive;
  logic ci_drive;
  logic down_next;
  logic grant;
  logic owner_w;
  logic hold_w;
  logic low_w;
  logic pri_ev;
  logic sec_ev;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic addr_phase;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Frame timing: eight hclk cycles per bit slot
  // ----------------------------------------------------------------
  assign last_cyc = (cyc_reg == arb_pkg::BIT_LAST_CYC);
  assign nbit = (bit_reg == arb_pkg::LAST_BIT) ? arb_pkg::FIRST_BIT : bit_reg + 5'h01;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_reg <= 3'h0;
      bit_reg <= arb_pkg::LAST_BIT;
      link.bit_clock <= 1'b0;
      link.frame_sync <= 1'b0;
    end else begin
      cyc_reg <= last_cyc ? 3'h0 : cyc_reg + 3'h1;
      if (last_cyc) begin
        bit_reg <= nbit;
        link.bit_clock <= 1'b1;
        link.frame_sync <= (nbit == arb_pkg::FIRST_BIT);
      end else if (cyc_reg == arb_pkg::HALF_LAST_CYC) begin
        link.bit_clock <= 1'b0;
      end
    end
  end

  // Upstream line comes from other parties; read back through two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_meta_reg <= 1'b1;
      up_s <= 1'b1;
    end else begin
      up_meta_reg <= link.upstream_data_line;
      up_s <= up_meta_reg;
    end
  end
  assign up_word = {up_sh_reg, up_s};

  // ----------------------------------------------------------------
  // Modes and arbitration
  // ----------------------------------------------------------------
  assign terminal = (serial_port_control_reg == arb_pkg::TERMINAL_MODE);
  assign arb_on = terminal && (data_interface_mode_field == arb_pkg::DIM_ARB);
  // Withdrawn request frees the bus for others
  assign req = arb_on & (primary_ci_transmit_reg[arb_pkg::BAC_POS] | hdlc_pending);

  bus_arbiter_core u_arb (
    .clk(hclk),
    .rst_n(hresetn),
    .enable(arb_on),
    .sample(last_cyc),
    .bit_idx(bit_reg),
    .line(up_s),
    .request(req),
    .address(sync_timing_control_reg),
    .drive_idx(nbit),
    .drive(arb_drive),
    .grant(grant),
    .owner_reg(owner_w),
    .hold_reg(hold_w),
    .low_prio_reg(low_w)
  );

  // Current owner puts its command code on the upstream primary slot
  always_comb begin
    ci_drive = 1'b0;
    if (arb_on && nbit <= arb_pkg::PRI_LAST) begin
      ci_drive = owner_w & ~primary_ci_transmit_reg[2'(arb_pkg::PRI_LAST - nbit)];
    end
  end

  assign cur_ind = (nbit == arb_pkg::FIRST_BIT) ? layer1_indication : ind_prev_reg;

  always_comb begin
    down_next = 1'b1;
    if (nbit <= arb_pkg::PRI_LAST) begin
      down_next = cur_ind[2'(arb_pkg::PRI_LAST - nbit)];
    end else if (nbit <= arb_pkg::SEC_LAST) begin
      down_next = terminal ? secondary_ci_transmit_reg[3'(arb_pkg::SEC_LAST - nbit)] : 1'b1;
    end else if (nbit == arb_pkg::STOP_BIT) begin
      down_next = d_channel_stop;
    end
  end

  assign link.up_out_dev = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.downstream_data_line <= 1'b1;
      link.up_oe_dev <= 1'b0;
    end else if (last_cyc) begin
      link.downstream_data_line <= down_next;
      link.up_oe_dev <= ci_drive | arb_drive;
    end
  end

  // ----------------------------------------------------------------
  // C/I codes
  // ----------------------------------------------------------------
  assign pri_ev = last_cyc && nbit == arb_pkg::FIRST_BIT && layer1_indication == ind_prev_reg &&
                  layer1_indication != primary_ci_receive_reg;
  assign sec_ev = last_cyc && bit_reg == arb_pkg::SEC_LAST && terminal &&
                  up_word != secondary_ci_receive_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind_prev_reg <= arb_pkg::PRI_RESET;
      primary_ci_receive_reg <= arb_pkg::PRI_RESET;
      secondary_ci_receive_reg <= arb_pkg::SEC_RESET;
      up_sh_reg <= 5'h1f;
      ext_code_reg <= arb_pkg::PRI_RESET;
      layer1_command <= arb_pkg::PRI_RESET;
    end else begin
      if (last_cyc && nbit == arb_pkg::FIRST_BIT) begin
        ind_prev_reg <= layer1_indication;
      end
      if (pri_ev) begin
        primary_ci_receive_reg <= layer1_indication;
      end
      if (sec_ev) begin
        secondary_ci_receive_reg <= up_word;
      end
      if (last_cyc) begin
        up_sh_reg <= up_word[4:0];
        if (bit_reg == arb_pkg::PRI_LAST) begin
          ext_code_reg <= up_word[3:0];
        end
        if (bit_reg == arb_pkg::LAST_BIT) begin
          layer1_command <= (!arb_on || owner_w) ? primary_ci_transmit_reg[3:0] : ext_code_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    case (haddr[7:0])
      arb_pkg::OFF_PRI_RX: rd_mux = 32'(primary_ci_receive_reg);
      arb_pkg::OFF_PRI_TX: rd_mux = 32'(primary_ci_transmit_reg);
      arb_pkg::OFF_SEC_RX: rd_mux = 32'(secondary_ci_receive_reg);
      arb_pkg::OFF_SEC_TX: rd_mux = 32'(secondary_ci_transmit_reg);
      arb_pkg::OFF_INT_STAT: rd_mux = 32'(interrupt_status_reg);
      arb_pkg::OFF_INT_MASK: rd_mux = 32'(interrupt_mask_reg);
      arb_pkg::OFF_SYNC_TIMING_CONTROL_REG: rd_mux = 32'(sync_timing_control_reg);
      arb_pkg::OFF_SERIAL_PORT_CONTROL_REG: rd_mux = 32'(serial_port_control_reg);
      arb_pkg::OFF_MODE: rd_mux = 32'(data_interface_mode_field);
      arb_pkg::OFF_ARB_STAT: rd_mux = 32'({d_channel_stop, low_w, hold_w, owner_w});
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_mux;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_ci_transmit_reg <= {1'b0, arb_pkg::PRI_RESET};
      secondary_ci_transmit_reg <= arb_pkg::SEC_RESET;
      interrupt_mask_reg <= 3'h0;
      sync_timing_control_reg <= arb_pkg::DEFAULT_ADDR;
      serial_port_control_reg <= arb_pkg::TERMINAL_MODE;
      data_interface_mode_field <= arb_pkg::DIM_RESET;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        arb_pkg::OFF_PRI_TX: primary_ci_transmit_reg <= hwdata[4:0];
        arb_pkg::OFF_SEC_TX: secondary_ci_transmit_reg <= hwdata[5:0];
        arb_pkg::OFF_INT_MASK: interrupt_mask_reg <= hwdata[2:0];
        arb_pkg::OFF_SYNC_TIMING_CONTROL_REG: sync_timing_control_reg <= hwdata[2:0];
        arb_pkg::OFF_SERIAL_PORT_CONTROL_REG: serial_port_control_reg <= hwdata[0];
        arb_pkg::OFF_MODE: data_interface_mode_field <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky, write one to clear, a new event beats the clear
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = 3'h0;
    irq_set[arb_pkg::IRQ_PRI] = pri_ev;
    irq_set[arb_pkg::IRQ_SEC] = sec_ev;
    irq_set[arb_pkg::IRQ_GRANT] = grant;
  end
  assign irq_clr = (wr_pend_reg && wr_addr_reg == arb_pkg::OFF_INT_STAT) ? hwdata[2:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_status_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      interrupt_status_reg <= (interrupt_status_reg & ~irq_clr) | irq_set;
      irq <= |(interrupt_status_reg & interrupt_mask_reg);
    end
  end
endmodule
`default_nettype wire

// ===== common/arb_pkg.sv
// Shared constants for the C/I channel and bus-access arbitration link
// Behaviour
// - Four-bit primary C/I code, receive and transmit registers
// - Primary access arbitrated only in terminal timing mode
// - Watch primary code each frame, flag changes
// - Primary code valid after two equal frames
// - Transmit register code resent every frame
// - Six-bit secondary C/I channel, terminal mode only
// - Secondary code change flagged at once
// - Arbitration in last channel-2 octet, seven controllers
// - Arbitration runs only when interface mode 001
// - Request from request bit or pending HDLC frame
// - Send address only when bus-accessed bit reads 1; the holder also sends it while driving that bit 0
// - Error-free address wins, lowest address wins contention
// - Holder drives bus-accessed bit 0 until withdrawn
// - After access, wait two free frames before retrying
// - Idle bus shows address 7, its owner wins
// - Software clears request bit when done
// - Downstream bit 12 reports stop 1, go 0
// - Controllers drive upstream wired-AND, read downstream
package arb_pkg;
  // ----------------------------------------------------------------
  // Link timing: hclk cycles per bit and bit slots of one frame
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST_CYC = 3'h7;
  localparam logic [2:0] HALF_LAST_CYC = 3'h3;
  localparam logic [4:0] FIRST_BIT = 5'h00;
  localparam logic [4:0] PRI_LAST = 5'h03;
  localparam logic [4:0] SEC_LAST = 5'h09;
  localparam logic [4:0] BA_BIT = 5'h0c;
  localparam logic [4:0] STOP_BIT = BA_BIT;
  localparam logic [4:0] ADDR_FIRST = 5'h0d;
  localparam logic [4:0] ADDR_LAST = 5'h0f;
  localparam logic [4:0] LAST_BIT = 5'h11;
  // ----------------------------------------------------------------
  // Arbitration and modes
  // ----------------------------------------------------------------
  localparam logic [2:0] DEFAULT_ADDR = 3'h7;
  localparam logic [2:0] DIM_ARB = 3'h1;
  localparam logic [2:0] DIM_RESET = 3'h0;
  localparam logic TERMINAL_MODE = 1'b0;
  localparam logic [1:0] FREE_FRAMES = 2'h2;
  localparam int BAC_POS = 4;
  // ----------------------------------------------------------------
  // Register byte offsets and interrupt bits
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PRI_RX = 8'h00;
  localparam logic [7:0] OFF_PRI_TX = 8'h04;
  localparam logic [7:0] OFF_SEC_RX = 8'h08;
  localparam logic [7:0] OFF_SEC_TX = 8'h0c;
  localparam logic [7:0] OFF_INT_STAT = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  localparam logic [7:0] OFF_SYNC_TIMING_CONTROL_REG = 8'h18;
  localparam logic [7:0] OFF_SERIAL_PORT_CONTROL_REG = 8'h1c;
  localparam logic [7:0] OFF_MODE = 8'h20;
  localparam logic [7:0] OFF_ARB_STAT = 8'h24;
  localparam logic [3:0] PRI_RESET = 4'hf;
  localparam logic [5:0] SEC_RESET = 6'h3f;
  localparam int IRQ_PRI = 0;
  localparam int IRQ_SEC = 1;
  localparam int IRQ_GRANT = 2;
endpackage

// ===== common/ci_link_if.sv
// Time-division link between the device end and one external controller
`timescale 1ns/100ps
`default_nettype none
interface ci_link_if;
  logic frame_sync;
  logic bit_clock;
  logic downstream_data_line;
  logic up_out_dev;
  logic up_oe_dev;
  logic up_out_ctl;
  logic up_oe_ctl;
  logic upstream_data_line;
  // Wired-AND with pull-up: any enabled driver putting out 0 wins
  assign upstream_data_line = ~((up_oe_dev & ~up_out_dev) | (up_oe_ctl & ~up_out_ctl));
  modport dev (
    output frame_sync,
    output bit_clock,
    output downstream_data_line,
    output up_out_dev,
    output up_oe_dev,
    input upstream_data_line
  );
  modport ctl (
    input frame_sync,
    input bit_clock,
    input downstream_data_line,
    input upstream_data_line,
    output up_out_ctl,
    output up_oe_ctl
  );
endinterface
`default_nettype wire

// ===== hdl/bus_arbiter_core.sv
// Per-frame bus-access contention engine shared by both ends
`timescale 1ns/100ps
`default_nettype none
module bus_arbiter_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic sample,
  input wire logic [4:0] bit_idx,
  input wire logic line,
  input wire logic request,
  input wire logic [2:0] address,
  input wire logic [4:0] drive_idx,
  output logic drive,
  output logic grant,
  output logic owner_reg,
  output logic hold_reg,
  output logic low_prio_reg
);
  logic cont_reg;
  logic cont_next;
  logic hold_next;
  logic [1:0] addr_sh_reg;
  logic [1:0] free_cnt_reg;
  logic in_addr;

  assign in_addr = (bit_idx >= arb_pkg::ADDR_FIRST) && (bit_idx <= arb_pkg::ADDR_LAST);

  always_comb begin
    cont_next = cont_reg;
    hold_next = hold_reg;
    if (sample && enable) begin
      if (bit_idx == arb_pkg::BA_BIT) begin
        cont_next = request & line & ~low_prio_reg & ~hold_reg;
      end else if (in_addr && address[2'(arb_pkg::ADDR_LAST - bit_idx)] && !line) begin
        cont_next = 1'b0;
      end
      if (bit_idx == arb_pkg::ADDR_LAST) begin
        hold_next = request & (hold_reg | cont_next);
        cont_next = 1'b0;
      end
    end
    if (!enable) begin
      cont_next = 1'b0;
      hold_next = 1'b0;
    end
  end

  assign grant = hold_next & ~hold_reg;

  // Bus-accessed bit and address bits; a 1 is sent by not driving
  always_comb begin
    drive = 1'b0;
    if (enable && drive_idx == arb_pkg::BA_BIT) begin
      drive = hold_reg & request;
    end else if (enable && drive_idx >= arb_pkg::ADDR_FIRST && drive_idx <= arb_pkg::ADDR_LAST) begin
      drive = (cont_next | (hold_reg & request)) & ~address[2'(arb_pkg::ADDR_LAST - drive_idx)];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cont_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      cont_reg <= cont_next;
      hold_reg <= hold_next;
    end
  end

  // Address seen on the line names the owner; idle line reads 7
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_sh_reg <= 2'h0;
      owner_reg <= 1'b0;
    end else if (sample) begin
      addr_sh_reg <= {addr_sh_reg[0], line};
      if (bit_idx == arb_pkg::ADDR_LAST) begin
        owner_reg <= enable & ({addr_sh_reg, line} == address);
      end
    end
  end

  // Lower priority class after a win until two free frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      free_cnt_reg <= 2'h0;
      low_prio_reg <= 1'b0;
    end else if (grant) begin
      free_cnt_reg <= 2'h0;
      low_prio_reg <= 1'b1;
    end else begin
      if (sample && bit_idx == arb_pkg::BA_BIT) begin
        if (!line) begin
          free_cnt_reg <= 2'h0;
        end else if (free_cnt_reg != arb_pkg::FREE_FRAMES) begin
          free_cnt_reg <= free_cnt_reg + 2'h1;
        end
      end
      if (free_cnt_reg == arb_pkg::FREE_FRAMES) begin
        low_prio_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/ci_arb_controller.sv
// External layer-2 controller end of the link
`timescale 1ns/100ps
`default_nettype none
module ci_arb_controller (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic request,
  input wire logic [2:0] bus_address,
  input wire logic [3:0] command,
  input wire logic [5:0] secondary_tx,
  output logic [3:0] indication,
  output logic [5:0] secondary_rx,
  output logic owner,
  output logic holding,
  output logic stop,
  ci_link_if.ctl link
);
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic fs_s;
  logic bc_s;
  logic dd_s;
  logic ul_s;
  logic bc_d_reg;
  logic rise;
  logic sample;
  logic aligned_reg;
  logic [4:0] bit_reg;
  logic [4:0] nbit;
  logic [4:0] dsh_reg;
  logic [5:0] d_word;
  logic arb_drive;
  logic ci_drive;
  logic owner_w;
  logic hold_w;

  // ----------------------------------------------------------------
  // Pin synchronisers; clocks idle low, data lines idle high
  // ----------------------------------------------------------------
  // Reset to the idle levels so that no false bit clock edge follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 4'h3;
      sync_reg <= 4'h3;
    end else begin
      meta_reg <= {link.frame_sync, link.bit_clock, link.downstream_data_line, link.upstream_data_line};
      sync_reg <= meta_reg;
    end
  end
  assign {fs_s, bc_s, dd_s, ul_s} = sync_reg;

  // Drive on the rising bit clock, sample mid-bit on the falling one
  assign rise = bc_s & ~bc_d_reg;
  assign sample = ~bc_s & bc_d_reg & aligned_reg;
  assign nbit = (fs_s || bit_reg == arb_pkg::LAST_BIT) ? arb_pkg::FIRST_BIT : bit_reg + 5'h01;
  assign d_word = {dsh_reg, dd_s};

  always_comb begin
    ci_drive = 1'b0;
    if (nbit <= arb_pkg::PRI_LAST) begin
      ci_drive = owner_w & ~command[2'(arb_pkg::PRI_LAST - nbit)];
    end else if (nbit <= arb_pkg::SEC_LAST) begin
      ci_drive = ~secondary_tx[3'(arb_pkg::SEC_LAST - nbit)];
    end
  end

  bus_arbiter_core u_arb (
    .clk(hclk),
    .rst_n(hresetn),
    .enable(1'b1),
    .sample(sample),
    .bit_idx(bit_reg),
    .line(ul_s),
    .request(request),
    .address(bus_address),
    .drive_idx(nbit),
    .drive(arb_drive),
    .grant(),
    .owner_reg(owner_w),
    .hold_reg(hold_w),
    .low_prio_reg()
  );

  // ----------------------------------------------------------------
  // Bit position and upstream drive
  // ----------------------------------------------------------------
  assign link.up_out_ctl = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bc_d_reg <= 1'b0;
      aligned_reg <= 1'b0;
      bit_reg <= arb_pkg::LAST_BIT;
      link.up_oe_ctl <= 1'b0;
    end else begin
      bc_d_reg <= bc_s;
      if (rise) begin
        bit_reg <= nbit;
        aligned_reg <= aligned_reg | fs_s;
        link.up_oe_ctl <= (aligned_reg | fs_s) & (ci_drive | arb_drive);
      end
    end
  end

  // ----------------------------------------------------------------
  // Downstream C/I and stop/go reading
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsh_reg <= 5'h1f;
      indication <= arb_pkg::PRI_RESET;
      secondary_rx <= arb_pkg::SEC_RESET;
      stop <= 1'b1;
      owner <= 1'b0;
      holding <= 1'b0;
    end else begin
      owner <= owner_w;
      holding <= hold_w;
      if (sample) begin
        dsh_reg <= d_word[4:0];
        if (bit_reg == arb_pkg::PRI_LAST) begin
          indication <= d_word[3:0];
        end
        if (bit_reg == arb_pkg::SEC_LAST) begin
          secondary_rx <= d_word;
        end
        if (bit_reg == arb_pkg::STOP_BIT) begin
          stop <= dd_s;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/ci_arb_chk.sv
// Checker on the link signals between the device and the controller
`timescale 1ns/100ps
`default_nettype none
module ci_arb_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic frame_sync,
  input wire logic bit_clock,
  input wire logic downstream_data_line,
  input wire logic up_out_dev,
  input wire logic up_oe_dev,
  input wire logic up_out_ctl,
  input wire logic upstream_data_line
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Frame, bit and contention sequences
  // ----------------------------------------------------------------
  sequence frame_start;
    $rose(frame_sync);
  endsequence
  // Last cycle of the first address bit: device sent 1 but reads 0
  sequence lost_first;
    frame_start ##111 (!up_oe_dev && !upstream_data_line);
  endsequence
  sync_width_a: assert property (frame_start |-> frame_sync [*8] ##1 !frame_sync)
    else $error("frame sync width wrong");
  frame_period_a: assert property (frame_start |-> ##144 $rose(frame_sync))
    else $error("frame period wrong");
  bit_shape_a: assert property ($rose(bit_clock) |-> bit_clock [*4] ##1 !bit_clock [*4] ##1 bit_clock)
    else $error("bit clock shape wrong");
  frame_align_a: assert property (frame_start |-> $rose(bit_clock))
    else $error("frame start off a bit boundary");
  down_edge_a: assert property ($changed(downstream_data_line) |-> $rose(bit_clock))
    else $error("downstream changed inside a bit");
  oe_edge_a: assert property ($changed(up_oe_dev) |-> $rose(bit_clock))
    else $error("device upstream drive changed inside a bit");
  drive_low_a: assert property (!up_out_dev && !up_out_ctl)
    else $error("upstream driver puts out a one");
  // Two cycles of slack cover the output register at the bit start
  lose_stop_a: assert property (lost_first |-> ##2 !up_oe_dev [*6] ##1 !up_oe_dev [*8])
    else $error("device kept contending after losing");
  lost_c: cover property (lost_first);
endmodule
`default_nettype wire

// ===== test/test_ci_channel_bus_arbiter.sv
// Self-checking bench: device and controller joined over the link
`timescale 1ns/100ps
`default_nettype none
`define CMP(x, g) begin checks++; if ((g) !== (x)) begin bad_count++; \
  $display("[FAIL] t=%0t exp=%h got=%h", $time, x, g); end end
module test_ci_channel_bus_arbiter;
  logic hclk, hresetn, hsel, hwrite, hreadyout, irq, stp, ctl_req, ctl_own, ctl_stop, rv, pv, hresp, hp;
  logic [31:0] haddr, hwdata, hrdata, pobs, e;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] l1i, l1c, ctl_ind, r;
  logic [5:0] ctl_stx, ctl_srx, s;
  logic [31:0] q [$];
  logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h30};
  logic [7:0] vals [8] = '{8'h0f, 8'h0f, 8'h3f, 8'h3f, 8'h00, 8'h07, 8'h00, 8'h00};
  int bad_count, checks, cyc, seed;
  ci_link_if link();
  ci_arb_device i_ci_arb_device (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .layer1_indication(l1i), .layer1_command(l1c), .hdlc_pending(hp),
    .d_channel_stop(stp), .link(link.dev));
  ci_arb_controller i_ci_arb_controller (.hclk(hclk), .hresetn(hresetn), .request(ctl_req), .bus_address(3'h3),
    .command(4'h6), .secondary_tx(ctl_stx), .indication(ctl_ind), .secondary_rx(ctl_srx), .owner(ctl_own),
    .holding(), .stop(ctl_stop), .link(link.ctl));
  ci_arb_chk i_ci_arb_chk (.hclk(hclk), .hresetn(hresetn), .frame_sync(link.frame_sync),
    .bit_clock(link.bit_clock), .downstream_data_line(link.downstream_data_line), .up_out_dev(link.up_out_dev),
    .up_oe_dev(link.up_oe_dev), .up_out_ctl(link.up_out_ctl), .upstream_data_line(link.upstream_data_line));
  // ----------------------------------------------------------------
  // Clock, result watcher and hang limit
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (rv || pv) begin
      e = q.pop_front();
      `CMP(e, rv ? hrdata : pobs)
    end
    if (rv) `CMP(1'b0, hresp)
    if (cyc == 9000) begin
      bad_count++;
      end_sim();
    end
  end
  task end_sim();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bus and observation tasks
  // ----------------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) begin
      q.push_back(x);
      rv <= 1'b1;
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    xfer(1'b0, a, 32'h0, {24'h0, x});
  endtask
  // Expected value is queued first; the watcher pairs it with the sample
  task chk(input logic [7:0] x, input logic [7:0] g);
    q.push_back({24'h0, x});
    pobs <= {24'h0, g};
    pv <= 1'b1;
    @(posedge hclk);
    pv <= 1'b0;
    @(posedge hclk);
  endtask
  task fr(input int n);
    repeat (n * 144) @(posedge hclk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h0000_1b30;
    {hresetn, hsel, hwrite, rv, pv, stp, ctl_req, hp, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    l1i = 4'hf;
    ctl_stx = 6'h3f;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    wr(8'h00, 32'h0000_0005);
    foreach (offs[i]) rd(offs[i], vals[i]);
    $display("test registers done");
    l1i <= 4'ha;
    repeat (60) @(posedge hclk);
    l1i <= 4'hf;
    fr(3);
    rd(8'h00, 8'h0f);
    r = 4'($random(seed)) & 4'h7;
    l1i <= r;
    fr(3);
    wr(8'h14, 32'h0000_0007);
    rd(8'h00, {4'h0, r});
    rd(8'h10, 8'h01);
    chk(8'h01, {7'h0, irq});
    chk({4'h0, r}, {4'h0, ctl_ind});
    wr(8'h10, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk(8'h00, {7'h0, irq});
    s = 6'($random(seed)) & 6'h1f;
    ctl_stx <= s;
    fr(2);
    rd(8'h08, {2'h0, s});
    rd(8'h10, 8'h02);
    wr(8'h0c, 32'h0000_002a);
    wr(8'h10, 32'h0000_0002);
    wr(8'h04, 32'h0000_0009);
    fr(2);
    chk(8'h2a, {2'h0, ctl_srx});
    chk(8'h09, {4'h0, l1c});
    $display("test channels done");
    wr(8'h20, 32'h0000_0001);
    fr(2);
    rd(8'h24, 8'h01);
    wr(8'h18, 32'h0000_0004);
    @(posedge link.frame_sync);
    @(posedge hclk);
    ctl_req <= 1'b1;
    stp <= 1'b1;
    wr(8'h04, 32'h0000_0019);
    fr(3);
    chk(8'h01, {7'h0, ctl_own});
    chk(8'h06, {4'h0, l1c});
    chk(8'h01, {7'h0, ctl_stop});
    rd(8'h24, 8'h08);
    $display("test contention done");
    ctl_req <= 1'b0;
    stp <= 1'b0;
    fr(4);
    chk(8'h09, {4'h0, l1c});
    chk(8'h00, {7'h0, ctl_own});
    chk(8'h00, {7'h0, ctl_stop});
    rd(8'h10, 8'h04);
    chk(8'h01, {7'h0, irq});
    $display("test handover done");
    // Pending frame alone keeps the bus once the request bit is cleared
    hp <= 1'b1;
    wr(8'h04, 32'h0000_0009);
    fr(2);
    rd(8'h24, 8'h07);
    hp <= 1'b0;
    fr(3);
    rd(8'h24, 8'h00);
    wr(8'h1c, 32'h0000_0001);
    fr(2);
    chk(8'h3f, {2'h0, ctl_srx});
    chk(8'h09, {4'h0, l1c});
    $display("test release done");
    end_sim();
  end
endmodule
`default_nettype wire
